// file: rtl/frc_defines.vh
// register map, reset values and timing counts of the congestion controller
`ifndef FRC_DEFINES_VH
`define FRC_DEFINES_VH

// byte offsets of the apb registers
`define FRC_CLASS_OFS 8'h00
`define FRC_CREATE_OFS 8'h04
`define FRC_ENABLE_OFS 8'h08
`define FRC_STATUS_OFS 8'h0c
`define FRC_QRATE_OFS 8'h10
`define FRC_PRATE_OFS 8'h14
`define FRC_MRATE_OFS 8'h18
`define FRC_UPSTEP_OFS 8'h1c
`define FRC_DNSTEP_OFS 8'h20
`define FRC_CMAX_OFS 8'h24
`define FRC_DTEST_OFS 8'h28
`define FRC_PORT_THR_OFS 8'h30
`define FRC_VC_THR_OFS 8'h40
`define FRC_RATE_OFS 8'h80
`define FRC_RTD_OFS 8'hc0

// field positions
`define FRC_STATUS_PORT_LSB 16
`define FRC_DTEST_BUSY_BIT 31

// reset values
`define FRC_QRATE_RST 16'h0800
`define FRC_PRATE_RST 16'h1000
`define FRC_MRATE_RST 16'h0400
`define FRC_UPSTEP_RST 16'h0040
`define FRC_DNSTEP_RST 16'h0100
`define FRC_CMAX_RST 8'h04
`define FRC_VC_THR_RST 16'h0020
`define FRC_PORT_THR_RST 16'h0040

// timing: rate adjust period
`define FRC_CLK_MHZ 10
`define FRC_ADJ_PERIOD_US 100
`define FRC_ADJ_CYCLES (`FRC_ADJ_PERIOD_US * `FRC_CLK_MHZ)
// timing: round-trip probe period, 100 ms
`define FRC_PROBE_PERIOD_MS 100
`define FRC_PROBE_CYCLES (`FRC_PROBE_PERIOD_MS * 1000 * `FRC_CLK_MHZ)

`endif

// file: rtl/frc_congestion_ctrl.v
// congestion notification and adaptive rate control for a port card
`timescale 1ns/1ns
// ==========================================================================
// What this block does
// - count fill depth of each circuit's own input queue
// - input fill above circuit threshold marks that circuit congested
// - congested circuit gets forward bit in frames toward network
// - congested circuit gets backward bit in frames toward its user
// - per port, separate high and low priority output queue depths
// - output fill above port threshold marks whole port congested
// - congested port sets forward to user, backward toward network
// - adaptive circuit starts a burst at the quiescent rate
// - without feedback rate rises in small steps, capped at peak
// - near-full trunk queue sets internal forward bit on passing packets
// - received internal forward bit returns rate adjust bit to source
// - rate adjust bit lowers rate in larger steps, floor at minimum
// - current rate sets how often credits are granted
// - transmit and receive directions keep separate rate state
// - non-adaptive circuit accrues credits at fixed minimum rate
// - adaptive and plain traffic use separate trunk queues
// - new circuit takes class adaptive setting; may be disabled later
// - periodic high-priority probe measures each adaptive circuit's round trip
// - received probe is echoed back unchanged
// - user delay test on request, ordinary packet, result kept
// - one credit per admitted packet; none admitted at zero balance
// - unused credits saturate at the maximum credit count
// ==========================================================================
`include "frc_defines.vh"

module frc_congestion_ctrl #(
  parameter VCW = 2,
  parameter PW = 1,
  parameter DW = 16,
  parameter PROBE_CYCLES = `FRC_PROBE_CYCLES
) (
  input wire sys_clk,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // circuit input queues
  input wire in_enq,
  input wire [VCW-1:0] in_enq_vc,
  input wire in_deq,
  input wire [VCW-1:0] in_deq_vc,
  // port output queues
  input wire pq_enq,
  input wire [PW-1:0] pq_enq_port,
  input wire pq_enq_hi,
  input wire pq_deq,
  input wire [PW-1:0] pq_deq_port,
  input wire pq_deq_hi,
  // frame header marking
  input wire hdr_valid,
  input wire [VCW-1:0] hdr_vc,
  input wire [PW-1:0] hdr_port,
  input wire hdr_to_user,
  output reg mark_valid,
  output reg mark_fecn,
  output reg mark_becn,
  // trunk pass-through
  input wire trk_valid,
  input wire trk_efc,
  input wire trk_adaptive,
  input wire trk_full_adaptive,
  input wire trk_full_plain,
  output reg trk_out_valid,
  output reg trk_out_efc,
  output reg trk_out_adaptive,
  // destination feedback
  input wire rx_valid,
  input wire [VCW:0] rx_ch,
  input wire rx_efc,
  output reg ra_valid,
  output reg [VCW:0] ra_ch,
  output reg ra_bit,
  input wire fb_valid,
  input wire [VCW:0] fb_ch,
  input wire fb_ra,
  // credit grants, channel = {vc, dir}
  input wire [(2<<VCW)-1:0] pkt_req,
  output reg [(2<<VCW)-1:0] pkt_grant,
  // delay measurement
  output reg meas_send,
  output reg [VCW:0] meas_ch,
  output reg meas_hipri,
  input wire meas_ret_valid,
  input wire [VCW:0] meas_ret_ch,
  input wire probe_in_valid,
  input wire [VCW:0] probe_in_ch,
  output reg probe_echo_valid,
  output reg [VCW:0] probe_echo_ch
);

  localparam NVC = 1 << VCW;
  localparam NCH = 2 << VCW;
  localparam NP = 1 << PW;
  localparam [31:0] ADJ_LAST = `FRC_ADJ_CYCLES - 1;
  localparam [31:0] PROBE_LAST = PROBE_CYCLES - 1;

  integer i;

  // ========================================================================
  // configuration registers
  reg class_adaptive;
  reg [NVC-1:0] adaptive_en;
  reg [15:0] quiescent_rate;
  reg [15:0] peak_rate;
  reg [15:0] minimum_rate;
  reg [15:0] up_step;
  reg [15:0] down_step;
  reg [7:0] cmax;
  reg [DW-1:0] circuit_queue_congestion_threshold [0:NVC-1];
  reg [DW-1:0] port_queue_congestion_threshold [0:NP-1];

  // ========================================================================
  // state
  reg [DW-1:0] vc_depth [0:NVC-1];
  reg [DW-1:0] hi_depth [0:NP-1];
  reg [DW-1:0] lo_depth [0:NP-1];
  reg [NVC-1:0] vc_cong;
  reg [NP-1:0] port_cong;
  reg [15:0] rate [0:NCH-1];
  reg [15:0] acc [0:NCH-1];
  reg [7:0] credit [0:NCH-1];
  reg [NCH-1:0] down_pend;
  reg [31:0] adj_cnt;
  reg [15:0] rtd [0:NCH-1];
  reg [15:0] dtest_result;
  reg dtest_pend;
  reg [VCW:0] dtest_ch;
  reg meas_busy;
  reg meas_user;
  reg [15:0] meas_cnt;
  reg [31:0] probe_cnt;
  reg [VCW:0] probe_ch;

  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite;
  wire [5:0] widx = paddr[7:2];
  wire [3:0] aidx = paddr[5:2];
  wire adj_tick = (adj_cnt == ADJ_LAST);
  reg [31:0] next_prdata;
  reg next_err;

  // ========================================================================
  // read mux, latched in the setup cycle so the answer is a flop
  always @* begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    case (paddr)
      `FRC_CLASS_OFS: next_prdata[0] = class_adaptive;
      `FRC_CREATE_OFS: next_prdata = 32'h00000000;
      `FRC_ENABLE_OFS: next_prdata[NVC-1:0] = adaptive_en;
      `FRC_STATUS_OFS: begin
        next_prdata[NVC-1:0] = vc_cong;
        next_prdata[`FRC_STATUS_PORT_LSB+NP-1:`FRC_STATUS_PORT_LSB] =
          port_cong;
      end
      `FRC_QRATE_OFS: next_prdata[15:0] = quiescent_rate;
      `FRC_PRATE_OFS: next_prdata[15:0] = peak_rate;
      `FRC_MRATE_OFS: next_prdata[15:0] = minimum_rate;
      `FRC_UPSTEP_OFS: next_prdata[15:0] = up_step;
      `FRC_DNSTEP_OFS: next_prdata[15:0] = down_step;
      `FRC_CMAX_OFS: next_prdata[7:0] = cmax;
      `FRC_DTEST_OFS: begin
        next_prdata[15:0] = dtest_result;
        next_prdata[`FRC_DTEST_BUSY_BIT] =
          dtest_pend | (meas_busy & meas_user);
      end
      default: begin
        if (widx >= 6'h0c && widx < 6'h0c + NP)
          next_prdata[DW-1:0] = port_queue_congestion_threshold[aidx[PW-1:0]];
        else if (widx >= 6'h10 && widx < 6'h10 + NVC)
          next_prdata[DW-1:0] =
            circuit_queue_congestion_threshold[aidx[VCW-1:0]];
        else if (widx >= 6'h20 && widx < 6'h20 + NCH)
          next_prdata[15:0] = rate[aidx[VCW:0]];
        else if (widx >= 6'h30 && widx < 6'h30 + NCH)
          next_prdata[15:0] = rtd[aidx[VCW:0]];
        else
          next_err = 1'b1;
      end
    endcase
  end

  // ========================================================================
  // apb handshake: one wait-free access phase after each setup
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_err;
      end
    end
  end

  // ========================================================================
  // configuration writes; thresholds steer the congestion marking
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      class_adaptive <= 1'b0;
      adaptive_en <= {NVC{1'b0}};
      quiescent_rate <= `FRC_QRATE_RST;
      peak_rate <= `FRC_PRATE_RST;
      minimum_rate <= `FRC_MRATE_RST;
      up_step <= `FRC_UPSTEP_RST;
      down_step <= `FRC_DNSTEP_RST;
      cmax <= `FRC_CMAX_RST;
      for (i = 0; i < NVC; i = i + 1)
        circuit_queue_congestion_threshold[i] <= `FRC_VC_THR_RST;
      for (i = 0; i < NP; i = i + 1)
        port_queue_congestion_threshold[i] <= `FRC_PORT_THR_RST;
    end else if (apb_wr) begin
      case (paddr)
        `FRC_CLASS_OFS: class_adaptive <= pwdata[0];
        // circuit creation copies the class setting
        `FRC_CREATE_OFS: adaptive_en[pwdata[VCW-1:0]] <= class_adaptive;
        `FRC_ENABLE_OFS: adaptive_en <= pwdata[NVC-1:0];
        `FRC_QRATE_OFS: quiescent_rate <= pwdata[15:0];
        `FRC_PRATE_OFS: peak_rate <= pwdata[15:0];
        `FRC_MRATE_OFS: minimum_rate <= pwdata[15:0];
        `FRC_UPSTEP_OFS: up_step <= pwdata[15:0];
        `FRC_DNSTEP_OFS: down_step <= pwdata[15:0];
        `FRC_CMAX_OFS: cmax <= pwdata[7:0];
        default: begin
          if (widx >= 6'h0c && widx < 6'h0c + NP)
            port_queue_congestion_threshold[aidx[PW-1:0]] <= pwdata[DW-1:0];
          else if (widx >= 6'h10 && widx < 6'h10 + NVC)
            circuit_queue_congestion_threshold[aidx[VCW-1:0]] <=
              pwdata[DW-1:0];
        end
      endcase
    end
  end

  // ========================================================================
  // queue depth tracking and congestion marking
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < NVC; i = i + 1)
        vc_depth[i] <= {DW{1'b0}};
      for (i = 0; i < NP; i = i + 1) begin
        hi_depth[i] <= {DW{1'b0}};
        lo_depth[i] <= {DW{1'b0}};
      end
      vc_cong <= {NVC{1'b0}};
      port_cong <= {NP{1'b0}};
    end else begin
      // each circuit owns its input depth counter
      for (i = 0; i < NVC; i = i + 1) begin
        if (in_enq && in_enq_vc == i && !(in_deq && in_deq_vc == i))
          vc_depth[i] <= vc_depth[i] + 1'b1;
        else if (in_deq && in_deq_vc == i && !(in_enq && in_enq_vc == i) &&
                 vc_depth[i] != 0)
          vc_depth[i] <= vc_depth[i] - 1'b1;
        // strictly above marks, at or below clears
        vc_cong[i] <= vc_depth[i] > circuit_queue_congestion_threshold[i];
      end
      // shared per-port high and low queues
      for (i = 0; i < NP; i = i + 1) begin
        if (pq_enq && pq_enq_port == i && pq_enq_hi &&
            !(pq_deq && pq_deq_port == i && pq_deq_hi))
          hi_depth[i] <= hi_depth[i] + 1'b1;
        else if (pq_deq && pq_deq_port == i && pq_deq_hi &&
                 !(pq_enq && pq_enq_port == i && pq_enq_hi) &&
                 hi_depth[i] != 0)
          hi_depth[i] <= hi_depth[i] - 1'b1;
        if (pq_enq && pq_enq_port == i && !pq_enq_hi &&
            !(pq_deq && pq_deq_port == i && !pq_deq_hi))
          lo_depth[i] <= lo_depth[i] + 1'b1;
        else if (pq_deq && pq_deq_port == i && !pq_deq_hi &&
                 !(pq_enq && pq_enq_port == i && !pq_enq_hi) &&
                 lo_depth[i] != 0)
          lo_depth[i] <= lo_depth[i] - 1'b1;
        // whole port marked on total fill
        port_cong[i] <= ({1'b0, hi_depth[i]} + {1'b0, lo_depth[i]}) >
          {1'b0, port_queue_congestion_threshold[i]};
      end
    end
  end

  // ========================================================================
  // header marking; the user device does the throttling, not us
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mark_valid <= 1'b0;
      mark_fecn <= 1'b0;
      mark_becn <= 1'b0;
    end else begin
      mark_valid <= hdr_valid;
      if (hdr_to_user) begin
        mark_fecn <= hdr_valid & port_cong[hdr_port];
        mark_becn <= hdr_valid & vc_cong[hdr_vc];
      end else begin
        mark_fecn <= hdr_valid & vc_cong[hdr_vc];
        mark_becn <= hdr_valid & port_cong[hdr_port];
      end
    end
  end

  // ========================================================================
  // trunk transit, probe echo and rate adjust return
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trk_out_valid <= 1'b0;
      trk_out_efc <= 1'b0;
      trk_out_adaptive <= 1'b0;
      ra_valid <= 1'b0;
      ra_ch <= {(VCW+1){1'b0}};
      ra_bit <= 1'b0;
      probe_echo_valid <= 1'b0;
      probe_echo_ch <= {(VCW+1){1'b0}};
    end else begin
      trk_out_valid <= trk_valid;
      // each class looks only at its own trunk queue
      trk_out_efc <= trk_valid & (trk_efc |
        (trk_adaptive ? trk_full_adaptive : trk_full_plain));
      trk_out_adaptive <= trk_valid & trk_adaptive;
      ra_valid <= rx_valid;
      ra_ch <= rx_ch;
      ra_bit <= rx_valid & rx_efc;
      probe_echo_valid <= probe_in_valid;
      probe_echo_ch <= probe_in_ch;
    end
  end

  // ========================================================================
  // rate adjust timebase
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      adj_cnt <= 32'h00000000;
    else
      adj_cnt <= adj_tick ? 32'h00000000 : adj_cnt + 32'h00000001;
  end

  // ========================================================================
  // per-channel rate state; even channel transmit, odd receive
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      down_pend <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        rate[i] <= 16'h0000;
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        // a new indication wins over the tick that consumes the old one
        if (fb_valid && fb_ra && fb_ch == i)
          down_pend[i] <= 1'b1;
        else if (adj_tick)
          down_pend[i] <= 1'b0;
        if (apb_wr && paddr == `FRC_CREATE_OFS && pwdata[VCW-1:0] == i/2)
          rate[i] <= quiescent_rate;
        else if (i % 2 == 0 && in_enq && in_enq_vc == i/2 &&
                 vc_depth[i/2] == 0 && adaptive_en[i/2])
          rate[i] <= quiescent_rate; // burst onto idle queue
        else if (adj_tick && adaptive_en[i/2]) begin
          if (down_pend[i])
            rate[i] <= ({1'b0, rate[i]} > {1'b0, minimum_rate} +
              {1'b0, down_step}) ? rate[i] - down_step :
              minimum_rate;
          else
            rate[i] <= ({1'b0, rate[i]} + {1'b0, up_step} <
              {1'b0, peak_rate}) ? rate[i] + up_step : peak_rate;
        end
      end
    end
  end

  // ========================================================================
  // credit accrual and grants; rate is a fraction of one credit per cycle
  reg [16:0] acc_sum [0:NCH-1];
  integer j;
  // fixed minimum rate when adaptive control is off
  always @*
    for (j = 0; j < NCH; j = j + 1)
      acc_sum[j] = {1'b0, acc[j]} +
        {1'b0, adaptive_en[j/2] ? rate[j] : minimum_rate};
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pkt_grant <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        acc[i] <= 16'h0000;
        credit[i] <= 8'h00;
      end
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        acc[i] <= acc_sum[i][15:0];
        // no grant on an empty balance, one credit each
        pkt_grant[i] <= pkt_req[i] && credit[i] != 0 && !pkt_grant[i];
        if (pkt_req[i] && credit[i] != 0 && !pkt_grant[i]) begin
          if (!(acc_sum[i][16] && credit[i] <= cmax))
            credit[i] <= credit[i] - 1'b1;
        end else if (acc_sum[i][16] && credit[i] < cmax)
          credit[i] <= credit[i] + 1'b1; // saturates at cmax
      end
    end
  end

  // ========================================================================
  // round-trip measurement: periodic probe or user test, one at a time
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      probe_cnt <= 32'h00000000;
      probe_ch <= {(VCW+1){1'b0}};
      dtest_pend <= 1'b0;
      dtest_ch <= {(VCW+1){1'b0}};
      dtest_result <= 16'h0000;
      meas_busy <= 1'b0;
      meas_user <= 1'b0;
      meas_cnt <= 16'h0000;
      meas_send <= 1'b0;
      meas_ch <= {(VCW+1){1'b0}};
      meas_hipri <= 1'b0;
      for (i = 0; i < NCH; i = i + 1)
        rtd[i] <= 16'h0000;
    end else begin
      meas_send <= 1'b0;
      probe_cnt <= (probe_cnt == PROBE_LAST) ? 32'h00000000 :
        probe_cnt + 32'h00000001;
      // user test only on request
      if (apb_wr && paddr == `FRC_DTEST_OFS) begin
        dtest_pend <= 1'b1;
        dtest_ch <= pwdata[VCW:0];
      end
      if (meas_busy) begin
        // counter sticks at full scale rather than wrapping
        if (meas_cnt != 16'hffff)
          meas_cnt <= meas_cnt + 16'h0001;
        if (meas_ret_valid && meas_ret_ch == meas_ch) begin
          meas_busy <= 1'b0;
          if (meas_user)
            dtest_result <= meas_cnt; // kept for display
          else
            rtd[meas_ch] <= meas_cnt;
        end else if (probe_cnt == PROBE_LAST)
          meas_busy <= 1'b0; // lost probe, give up at next period
      end else if (dtest_pend && !(apb_wr && paddr == `FRC_DTEST_OFS)) begin
        dtest_pend <= 1'b0;
        meas_busy <= 1'b1;
        meas_user <= 1'b1;
        meas_cnt <= 16'h0000;
        meas_send <= 1'b1;
        meas_ch <= dtest_ch;
        meas_hipri <= 1'b0; // ordinary packet sees queuing
      end else if (probe_cnt == PROBE_LAST) begin
        probe_ch <= probe_ch + 1'b1;
        if (adaptive_en[probe_ch[VCW:1]]) begin
          meas_busy <= 1'b1;
          meas_user <= 1'b0;
          meas_cnt <= 16'h0000;
          meas_send <= 1'b1;
          meas_ch <= probe_ch;
          meas_hipri <= 1'b1; // high-priority probe
        end
      end
    end
  end

endmodule

// file: bench/frc_congestion_ctrl_properties.sv
// port assertions of the congestion controller
`timescale 1ns/1ns
// ======================================================================
// checker
module frc_props #(
  parameter VCW = 2
) (
  input wire sys_clk,
  input wire reset_n,
  input wire hdr_valid,
  input wire mark_valid,
  input wire trk_valid,
  input wire trk_adaptive,
  input wire trk_full_adaptive,
  input wire trk_full_plain,
  input wire trk_out_valid,
  input wire trk_out_efc,
  input wire trk_out_adaptive,
  input wire rx_valid,
  input wire [VCW:0] rx_ch,
  input wire rx_efc,
  input wire ra_valid,
  input wire [VCW:0] ra_ch,
  input wire ra_bit,
  input wire [(2<<VCW)-1:0] pkt_req,
  input wire [(2<<VCW)-1:0] pkt_grant,
  input wire meas_send,
  input wire probe_in_valid,
  input wire [VCW:0] probe_in_ch,
  input wire probe_echo_valid,
  input wire [VCW:0] probe_echo_ch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // every header gets its marking one cycle later
  AST_MARK: assert property (hdr_valid |=> mark_valid)
    else $error("header not marked");
  // no back-to-back grant on a channel
  AST_GAP: assert property (|pkt_grant |=>
    (pkt_grant & $past(pkt_grant)) == 0) else $error("grant too close");
  // a grant needs a pending request
  AST_REQ: assert property (|pkt_grant |->
    (pkt_grant & ~$past(pkt_req)) == 0) else $error("grant unasked");
  // packets keep their queue class
  AST_TRK: assert property (trk_valid |=> trk_out_valid &&
    trk_out_adaptive == $past(trk_adaptive)) else $error("trunk class");
  // a near full own queue sets the forward bit
  AST_EFC: assert property (trk_valid && (trk_adaptive ?
    trk_full_adaptive : trk_full_plain) |=> trk_out_efc)
    else $error("forward bit missing");
  // rate adjust returns the received forward bit
  AST_RA: assert property (rx_valid |=> ra_valid &&
    ra_bit == $past(rx_efc) && ra_ch == $past(rx_ch))
    else $error("rate adjust wrong");
  // probes come back unchanged
  AST_ECHO: assert property (probe_in_valid |=>
    probe_echo_valid && probe_echo_ch == $past(probe_in_ch))
    else $error("echo wrong");
  // no new launch in the two cycles after a launch
  AST_MEAS: assert property (meas_send |=> !meas_send [*2])
    else $error("launch overlap");
endmodule
bind frc_congestion_ctrl frc_props #(.VCW(VCW)) i_props (.*);

// file: bench/frc_far_end.sv
// far end model: returns probes and counts notified frames
`timescale 1ns/1ns
module frc_far_end #(
  parameter VCW = 2,
  parameter DLY = 10
) (
  input wire sys_clk,
  input wire reset_n,
  input wire meas_send,
  input wire [VCW:0] meas_ch,
  input wire mark_valid,
  input wire mark_fecn,
  input wire mark_becn,
  output reg meas_ret_valid,
  output reg [VCW:0] meas_ret_ch
);
  integer cnt, cong_seen;
  reg [VCW:0] ch;
  // idle channel toggles so a stale value is never trusted
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      cong_seen <= 0;
      ch <= 0;
      meas_ret_valid <= 0;
      meas_ret_ch <= 0;
    end else begin
      meas_ret_valid <= 0;
      meas_ret_ch <= ~meas_ret_ch;
      if (mark_valid && (mark_fecn || mark_becn))
        cong_seen <= cong_seen + 1;
      if (meas_send) begin
        cnt <= DLY;
        ch <= meas_ch;
      end else if (cnt == 1) begin
        meas_ret_valid <= 1;
        meas_ret_ch <= ch;
        cnt <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
    end
  end
endmodule

// file: bench/test_frc_congestion_ctrl.sv
// self-checking bench of the congestion controller
`timescale 1ns/1ns
`include "frc_defines.vh"
module test_frc_congestion_ctrl;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, pkt_req = 0;
  logic [31:0] pwdata = 0, q;
  logic e, in_enq = 0, in_deq = 0, pq_enq = 0, pq_deq = 0;
  logic pq_enq_hi = 0, pq_deq_hi = 0, hdr_valid = 0, hdr_to_user = 0;
  logic [1:0] in_enq_vc = 0, in_deq_vc = 0, hdr_vc = 0;
  logic pq_enq_port = 0, pq_deq_port = 0, hdr_port = 0, trk_valid = 0;
  logic trk_efc = 0, trk_adaptive = 0, trk_full_adaptive = 0;
  logic trk_full_plain = 0, rx_valid = 0, rx_efc = 0, fb_valid = 0;
  logic fb_ra = 0, probe_in_valid = 0;
  logic [2:0] rx_ch = 0, fb_ch = 0, probe_in_ch = 0;
  wire [31:0] prdata;
  wire [7:0] pkt_grant;
  wire [2:0] ra_ch, meas_ch, meas_ret_ch, probe_echo_ch;
  wire pready, pslverr, mark_valid, mark_fecn, mark_becn, ra_valid;
  wire trk_out_valid, trk_out_efc, trk_out_adaptive, ra_bit, meas_send;
  wire meas_hipri, meas_ret_valid, probe_echo_valid;
  integer n_mismatch = 0, checked = 0, n_gr = 0, n_hi = 0, n_lo = 0, i;
  always #50 sys_clk = ~sys_clk;
  // short probe period keeps the run brief
  frc_congestion_ctrl #(.PROBE_CYCLES(200)) i_dut (.*);
  frc_far_end i_far (.*);
  // count grants of channel 0 and launches by priority
  always @(posedge sys_clk) begin
    if (pkt_grant[0] === 1'b1) n_gr = n_gr + 1;
    if (meas_send === 1'b1 && meas_hipri === 1'b1) n_hi = n_hi + 1;
    if (meas_send === 1'b1 && meas_hipri === 1'b0) n_lo = n_lo + 1;
  end
  // ======================================================================
  // helpers
  task summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task ck(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, answer taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (pready !== 1 && k < 20);
    if (pready !== 1) begin n_mismatch++; summarize; end
    q = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0); ck(q, x);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] old);
    i = 0;
    do begin apb(0, a, 0); i++; end while (q === old && i < 500);
    if (i >= 500) begin n_mismatch++; summarize; end
  endtask
  task hdr(input logic [1:0] v, input logic p, u, f, b);
    @(posedge sys_clk);
    hdr_valid <= 1; hdr_vc <= v; hdr_port <= p; hdr_to_user <= u;
    @(posedge sys_clk);
    hdr_valid <= 0;
    @(negedge sys_clk);
    ck({mark_valid, mark_fecn, mark_becn}, {1'b1, f, b});
  endtask
  task inq(input logic enq, input logic [1:0] v, input integer n);
    @(posedge sys_clk);
    in_enq <= enq; in_deq <= !enq; in_enq_vc <= v; in_deq_vc <= v;
    repeat (n) @(posedge sys_clk);
    in_enq <= 0; in_deq <= 0;
    repeat (3) @(posedge sys_clk);
  endtask
  task fb;
    @(posedge sys_clk);
    fb_valid <= 1; fb_ch <= 2; fb_ra <= 1;
    @(posedge sys_clk);
    fb_valid <= 0;
  endtask
  // ======================================================================
  // scenarios
  task t_regs;
    rd(`FRC_QRATE_OFS, `FRC_QRATE_RST);
    rd(`FRC_PRATE_OFS, `FRC_PRATE_RST);
    rd(`FRC_MRATE_OFS, `FRC_MRATE_RST);
    rd(`FRC_UPSTEP_OFS, `FRC_UPSTEP_RST);
    rd(`FRC_DNSTEP_OFS, `FRC_DNSTEP_RST);
    rd(`FRC_CMAX_OFS, `FRC_CMAX_RST);
    rd(`FRC_VC_THR_OFS, `FRC_VC_THR_RST);
    rd(`FRC_PORT_THR_OFS, `FRC_PORT_THR_RST);
    apb(1, 8'h2c, 32'h5);
    ck(e, 1);
    rd(8'h2c, 0);
    ck(e, 1);
  endtask
  task t_src;
    apb(1, `FRC_VC_THR_OFS + 8'h4, 2);
    inq(1, 1, 3);
    rd(`FRC_STATUS_OFS, 32'h2);
    hdr(1, 0, 0, 1, 0);
    hdr(1, 0, 1, 0, 1);
    hdr(0, 0, 0, 0, 0);
    inq(0, 1, 1);
    hdr(1, 0, 0, 0, 0);
    inq(0, 1, 2);
  endtask
  task t_dst;
    apb(1, `FRC_PORT_THR_OFS, 1);
    @(posedge sys_clk);
    pq_enq <= 1; pq_enq_hi <= 1;
    @(posedge sys_clk);
    pq_enq_hi <= 0;
    @(posedge sys_clk);
    pq_enq <= 0;
    repeat (3) @(posedge sys_clk);
    rd(`FRC_STATUS_OFS, 32'h10000);
    hdr(2, 0, 1, 1, 0);
    hdr(3, 0, 0, 0, 1);
    @(posedge sys_clk);
    pq_deq <= 1;
    repeat (2) @(posedge sys_clk);
    pq_deq <= 0;
    repeat (3) @(posedge sys_clk);
    hdr(2, 0, 1, 0, 0);
  endtask
  task t_trk(input logic a, fa, fp, input logic [2:0] x);
    @(posedge sys_clk);
    trk_valid <= 1; trk_adaptive <= a;
    trk_full_adaptive <= fa; trk_full_plain <= fp;
    rx_valid <= 1; rx_ch <= 5; rx_efc <= fa;
    probe_in_valid <= 1; probe_in_ch <= 3;
    @(posedge sys_clk);
    trk_valid <= 0; rx_valid <= 0; probe_in_valid <= 0;
    @(negedge sys_clk);
    ck({trk_out_valid, trk_out_efc, trk_out_adaptive}, x);
    ck({ra_valid, ra_bit, ra_ch}, {1'b1, fa, 3'h5});
    ck({probe_echo_valid, probe_echo_ch}, 4'hb);
  endtask
  task t_credit;
    apb(1, `FRC_ENABLE_OFS, 0);
    repeat (600) @(posedge sys_clk);
    n_gr = 0;
    pkt_req[0] <= 1;
    repeat (9) @(posedge sys_clk);
    ck(n_gr, 4);
    repeat (640) @(posedge sys_clk);
    ck(n_gr >= 13 && n_gr <= 15, 1);
    pkt_req[0] <= 0;
  endtask
  task t_adapt;
    apb(1, `FRC_CLASS_OFS, 1);
    apb(1, `FRC_CREATE_OFS, 1);
    apb(1, `FRC_PRATE_OFS, 32'h860);
    rd(`FRC_ENABLE_OFS, 32'h2);
    rd(`FRC_RATE_OFS + 8'h8, 32'h800);
    fb;
    poll(`FRC_RATE_OFS + 8'hc, 32'h800);
    ck(q, 32'h840);
    rd(`FRC_RATE_OFS + 8'h8, 32'h700);
    poll(`FRC_RATE_OFS + 8'hc, 32'h840);
    ck(q, 32'h860);
    apb(1, `FRC_MRATE_OFS, 32'h700);
    fb;
    poll(`FRC_RATE_OFS + 8'h8, 32'h740);
    ck(q, 32'h700);
    inq(1, 1, 1);
    rd(`FRC_RATE_OFS + 8'h8, 32'h800);
    inq(0, 1, 1);
  endtask
  task t_meas;
    apb(1, `FRC_DTEST_OFS, 2);
    repeat (3) @(posedge sys_clk);
    i = 0;
    do begin apb(0, `FRC_DTEST_OFS, 0); i++; end while (q[31] && i < 300);
    ck(!q[31] && q[15:0] >= 7 && q[15:0] <= 12, 1);
    ck(n_lo, 1);
    repeat (900) @(posedge sys_clk);
    ck(n_hi > 0, 1);
    apb(0, `FRC_RTD_OFS + 8'h8, 0);
    ck(q >= 7 && q <= 12, 1);
  endtask
  // ======================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1;
    t_regs;
    t_src;
    t_dst;
    t_trk(1, 1, 0, 3'b111);
    t_trk(0, 1, 0, 3'b100);
    t_credit;
    t_adapt;
    t_meas;
    summarize;
  end
endmodule
